/* File: logic/sram_burst_port.sv */
// Functional notes
// [RL1] Register inputs; read data through output register
// [RL2] Second select active high, third active low
// [RL3] First select active low, part of selection
// [RL4] Drive data while drive enable low
// [RL5] First cycle after deselect start stays three-stated
// [RL6] Advance low steps burst address
// [RL7] Strobe captures address, low bits to counter
// [RL8] Both strobes low: processor strobe wins
// [RL9] Processor strobe ignored when first select high
// [RL10] Sleep input idles port, keeps contents
// [RL11] Capture data pins; read returns addressed word
// [RL12] Strap low linear, high interleaved, held static
// [RL13] Two-bit wraparound burst counter
// [RL14] Byte lanes qualified; global write writes all
// [RL15] Read needs strobe, selects, both writes high; processor strobe start reads regardless of writes
// [RL16] Address to array, data out next edge
// [RL17] Back-to-back single reads without idle cycles
// [RL18] Deselect: drive one more cycle, then release
// [RL19] Any write cycle three-states the data pins
// [RL20] Interleave XOR beat, linear add beat
module sram_burst_port
	import sram_port_pkg::*;
#(
	parameter int FIFO_DEPTH_P = FIFO_DEPTH
)(
	input  wire logic              mclk,                     // Clock, 25 MHz
	input  wire logic              resetn,                   // Asynchronous reset, low
	input  wire logic [ADDR_W-1:0] address,                  // Word address
	input  wire logic              select_low_first,         // First select, low
	input  wire logic              select_high_second,       // Second select, high
	input  wire logic              select_low_third,         // Third select, low
	input  wire logic              processor_addr_strobe_n,  // Processor strobe, low
	input  wire logic              controller_addr_strobe_n, // Controller strobe, low
	input  wire logic              burst_advance_n,          // Burst advance, low
	input  wire logic              global_write_n,           // Global write, low
	input  wire logic              byte_write_enable_n,      // Byte write enable, low
	input  wire logic [LANES-1:0]  byte_lane_select_n,       // Lane selects, low
	input  wire logic              drive_enable_n,           // Output drive enable, low
	input  wire logic              sleep_request,            // Sleep, high
	input  wire logic              burst_order_strap,        // High interleaved, low linear
	input  wire logic [DATA_W-1:0] data_in,                  // Data pins, input side
	output wire logic [DATA_W-1:0] data_out,                 // Data pins, output side
	output wire logic              data_oe,                  // Data pins driven
	output wire logic              write_ready,              // Write queue has room
	output wire logic              sleep_active              // Port asleep
);
	port_state_t       s;
	port_state_t       s_next;
	pins_t             p;
	logic              rst_s1;
	logic              rst_n;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] rd_data;
	logic              sleeping;
	logic              chip_sel;
	logic              proc_go;
	logic              ctrl_go;
	logic              strobe;
	logic              wr_req;
	logic              rd_quiet;
	logic [LANES-1:0]  lanes;
	logic              in_burst;
	logic              start;
	logic              desel;
	logic              cont;
	logic              beat_adv;
	logic [1:0]        beat_now;
	logic [1:0]        base_now;
	logic [ADDR_W-1:0] acc_addr;
	logic              do_write;
	logic              do_read;
	wr_entry_t         wq_in;
	wr_entry_t         wq_out;
	logic              wq_in_ready;
	logic              wq_out_valid;
	logic              drain;

	generate
		if (FIFO_DEPTH_P < 2 || (FIFO_DEPTH_P & (FIFO_DEPTH_P - 1)) != 0) begin : g_bad
			$error("Write queue depth must be a power of two");
		end
	endgenerate

	function automatic logic [1:0] burst_low(
		input logic [1:0] base,
		input logic [1:0] beat,
		input logic       interleave
	);
		if (interleave) begin
			burst_low = base ^ beat; // [RL20]
		end else begin
			burst_low = 2'(base + beat); // [RL20]
		end
	endfunction : burst_low

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Second synchroniser stage is the input register
	assign p        = s.pin2; // [RL1] [RL11]
	assign sleeping = p.sleep; // [RL10]
	assign chip_sel = ~p.sel_first_n & p.sel_second & ~p.sel_third_n; // [RL2] [RL3]
	assign proc_go  = ~p.proc_n & ~p.sel_first_n; // [RL9]
	assign ctrl_go  = ~p.ctrl_n & ~proc_go; // [RL8]
	assign strobe   = proc_go | ctrl_go;
	assign wr_req   = ~p.gw_n | (~p.bwe_n & (~p.bw_n != LANES_NONE));
	assign rd_quiet = p.gw_n & p.bwe_n; // [RL15]
	assign lanes    = p.gw_n ? (~p.bw_n & {LANES{~p.bwe_n}}) : LANES_ALL; // [RL14]
	assign in_burst = (s.st == ST_BURST);
	assign start    = ~sleeping & strobe & chip_sel;
	assign desel    = ~sleeping & strobe & ~chip_sel;
	assign cont     = ~sleeping & ~strobe & in_burst;
	assign beat_adv = cont & ~p.adv_n; // [RL6]

	// Two-bit counter wraps by width
	always_comb begin
		if (!cont) begin
			beat_now = BEAT_FIRST;
		end else if (beat_adv) begin
			beat_now = 2'(s.beat + BEAT_STEP); // [RL13]
		end else begin
			beat_now = s.beat;
		end
	end

	assign base_now = start ? p.addr[1:0] : s.base; // [RL7]
	assign acc_addr = {(start ? p.addr[ADDR_W-1:2] : s.addr[ADDR_W-1:2]),
		burst_low(base_now, beat_now, p.strap)}; // [RL12]

	// Processor-strobe start ignores write inputs in its first cycle
	assign do_write = (start & ctrl_go & wr_req) | (cont & wr_req);
	assign do_read  = (start & (proc_go | rd_quiet)) | (cont & rd_quiet); // [RL15] [RL17]

	assign wq_in.addr  = acc_addr;
	assign wq_in.lanes = lanes;
	assign wq_in.data  = p.data; // [RL11]

	// Reads own the array port; queued writes drain in any cycle without a read.
	// Limitation: a read of a word still queued returns the old value.
	assign drain = wq_out_valid & ~do_read;

	sram_write_fifo #(
		.WIDTH ($bits(wr_entry_t)),
		.DEPTH (FIFO_DEPTH_P)
	) u_wq (
		.clk       (mclk),
		.rst_n     (rst_n),
		.in_data   (wq_in),
		.in_valid  (do_write),
		.in_ready  (wq_in_ready),
		.out_data  (wq_out),
		.out_valid (wq_out_valid),
		.out_ready (drain)
	);

	always_comb begin
		s_next = s;
		s_next.pin1 = {address, select_low_first, select_high_second, select_low_third,
			processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
			global_write_n, byte_write_enable_n, byte_lane_select_n, drive_enable_n,
			sleep_request, burst_order_strap, data_in}; // [RL1]
		s_next.pin2 = s.pin1;
		s_next.wr_ready = wq_in_ready;
		case (s.st)
			ST_DESEL,
			ST_BURST: begin
				if (sleeping) begin
					s_next.st = ST_SLEEP; // [RL10]
				end else if (start) begin
					s_next.st   = ST_BURST; // [RL7]
					s_next.addr = p.addr;
					s_next.base = p.addr[1:0];
					s_next.beat = BEAT_FIRST;
				end else if (desel) begin
					s_next.st = ST_DESEL;
				end else if (cont) begin
					s_next.beat = beat_now; // [RL13]
				end
			end
			ST_SLEEP: begin
				if (!sleeping) begin
					s_next.st = ST_DESEL;
				end
			end
			default: begin
				s_next.st = ST_DESEL;
			end
		endcase
		s_next.asleep = (s_next.st == ST_SLEEP);
		// Old burst state: masks a fresh start, holds one cycle after deselect
		s_next.data_oe = in_burst & ~p.oe_n & ~do_write & ~sleeping; // [RL4] [RL5] [RL18] [RL19]
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s    <= '0;
			s.st <= ST_RESET;
		end else begin
			s <= s_next;
		end
	end

	// Array and output register; contents survive sleep
	always_ff @(posedge mclk) begin
		if (drain) begin
			for (int i = 0; i < LANES; i++) begin
				if (wq_out.lanes[i]) begin
					mem[wq_out.addr][i*LANE_W +: LANE_W] <= wq_out.data[i*LANE_W +: LANE_W]; // [RL14]
				end
			end
		end
		if (do_read) begin
			rd_data <= mem[acc_addr]; // [RL16]
		end
	end

	assign data_out     = rd_data;
	assign data_oe      = s.data_oe;
	assign write_ready  = s.wr_ready;
	assign sleep_active = s.asleep;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence dcd_tail;
		data_oe ##1 !data_oe;
	endsequence

	sequence fresh_start;
		(s.st == ST_DESEL) && start;
	endsequence

	sequence burst_desel;
		in_burst && desel && !p.oe_n;
	endsequence

	AST_FIRST_MASK: assert property (fresh_start |=> !data_oe) // [RL5]
		else $error("Output driven in first cycle after deselected start");

	AST_DCD_HOLD: assert property (burst_desel |=> dcd_tail) // [RL18]
		else $error("Deselect did not hold then release outputs");

	AST_WRITE_TRI: assert property (do_write |=> !data_oe) // [RL19]
		else $error("Outputs driven during write cycle");

	AST_OE_HIGH: assert property (p.oe_n |=> !data_oe) // [RL4]
		else $error("Outputs driven while drive enable high");

	AST_OE_LOW: assert property (in_burst && !p.oe_n && !do_write && !sleeping |=> data_oe) // [RL4]
		else $error("Outputs not driven while enabled in burst");

	AST_PROC_IGNORED: assert property (p.sel_first_n && p.ctrl_n |-> !start && !desel) // [RL9]
		else $error("Processor strobe accepted with first select high");

	AST_PROC_WINS: assert property (!p.proc_n && !p.ctrl_n && chip_sel && !sleeping |-> !do_write && do_read) // [RL8]
		else $error("Controller strobe acted on beside processor strobe");

	AST_CAPTURE: assert property (start |=> s.addr == $past(p.addr) && s.beat == BEAT_FIRST) // [RL7]
		else $error("Address not captured on strobe");

	AST_ADVANCE: assert property (beat_adv && !sleeping |=> s.beat == 2'($past(s.beat) + BEAT_STEP)) // [RL6]
		else $error("Burst counter did not step on advance");

	AST_HOLD_BEAT: assert property (cont && p.adv_n |=> $stable(s.beat)) // [RL13]
		else $error("Burst counter moved without advance");

	AST_SLEEP: assert property (sleeping [*2] |-> !start && !do_write ##1 sleep_active && !data_oe) // [RL10]
		else $error("Port active during sleep");

	AST_READ_PIPE: assert property (do_read |=> rd_data == $past(mem[acc_addr])) // [RL16]
		else $error("Read data not registered one edge after access");

	AST_NO_DRAIN_ON_READ: assert property (do_read |-> !drain) // [RL17]
		else $error("Queued write collided with read");

	sequence wake_up;
		sleep_active && !sleeping;
	endsequence

	sequence b2b_read;
		in_burst && start && rd_quiet && !p.oe_n;
	endsequence

	AST_SEL_SECOND: assert property (!p.sel_second |-> !start) // [RL2]
		else $error("Start accepted with second select low");

	AST_SEL_THIRD: assert property (p.sel_third_n |-> !start) // [RL2]
		else $error("Start accepted with third select high");

	AST_SEL_FIRST: assert property (p.sel_first_n |-> !start) // [RL3]
		else $error("Start accepted with first select high");

	AST_CTRL_START: assert property (!p.ctrl_n && p.proc_n && chip_sel && !sleeping |-> start && ctrl_go) // [RL7]
		else $error("Controller strobe not recognised");

	AST_START_ADDR: assert property (start |-> acc_addr == p.addr) // [RL7] [RL16]
		else $error("Strobe cycle did not present captured address");

	AST_BASE_LOAD: assert property (start |=> s.base == $past(p.addr[1:0])) // [RL7]
		else $error("Low address bits not loaded into counter");

	AST_ADDR_HOLD: assert property (cont |=> $stable(s.addr) && $stable(s.base)) // [RL13]
		else $error("Burst start address moved during burst");

	AST_LINEAR_ADDR: assert property (cont && !p.strap |-> acc_addr[1:0] == 2'(s.base + beat_now)) // [RL12] [RL20]
		else $error("Linear burst address wrong");

	AST_INTERLEAVE_ADDR: assert property (cont && p.strap |-> acc_addr[1:0] == (s.base ^ beat_now)) // [RL12] [RL20]
		else $error("Interleaved burst address wrong");

	AST_BURST_UPPER: assert property (cont |-> acc_addr[ADDR_W-1:2] == s.addr[ADDR_W-1:2]) // [RL13]
		else $error("Burst left its four-word group");

	AST_LANES_GLOBAL: assert property (!p.gw_n |-> lanes == LANES_ALL) // [RL14]
		else $error("Global write did not select all lanes");

	AST_LANES_BYTE: assert property (p.gw_n && p.bwe_n |-> lanes == LANES_NONE) // [RL14]
		else $error("Lanes selected without byte write enable");

	AST_WRITE_LANES: assert property (do_write |-> wq_in.lanes != LANES_NONE) // [RL14]
		else $error("Write queued with no lane");

	AST_QUEUE_TAKE: assert property (do_write && wq_in_ready |=> wq_out_valid) // [RL14]
		else $error("Accepted write missing from queue");

	AST_CONT_READ: assert property (cont && do_read |-> p.gw_n && p.bwe_n) // [RL15]
		else $error("Burst read with write inputs active");

	AST_DESEL_STATE: assert property (desel |=> s.st == ST_DESEL) // [RL18]
		else $error("Deselect not taken");

	AST_WAKE: assert property (wake_up |=> !sleep_active && s.st == ST_DESEL) // [RL10]
		else $error("Port did not leave sleep deselected");

	AST_B2B_DRIVE: assert property (b2b_read |=> data_oe) // [RL17]
		else $error("Back-to-back read not driven");
endmodule : sram_burst_port

/* File: include/sram_port_pkg.sv */
package sram_port_pkg;
	localparam int         ADDR_W     = 17;
	localparam int         DATA_W     = 32;
	localparam int         LANES      = 4;
	localparam int         LANE_W     = 8;
	localparam int         FIFO_DEPTH = 16;
	localparam logic [3:0] LANES_ALL  = 4'hF;
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_STEP  = 2'h1;

	// One-hot access states
	typedef enum logic [2:0] {
		ST_DESEL = 3'h1,
		ST_BURST = 3'h2,
		ST_SLEEP = 3'h4
	} access_st_t;

	localparam access_st_t ST_RESET = ST_DESEL;

	// Snapshot of every input pin except clock and reset
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              sel_first_n;
		logic              sel_second;
		logic              sel_third_n;
		logic              proc_n;
		logic              ctrl_n;
		logic              adv_n;
		logic              gw_n;
		logic              bwe_n;
		logic [LANES-1:0]  bw_n;
		logic              oe_n;
		logic              sleep;
		logic              strap;
		logic [DATA_W-1:0] data;
	} pins_t;

	// One queued array write
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  lanes;
		logic [DATA_W-1:0] data;
	} wr_entry_t;

	typedef struct packed {
		pins_t             pin1;
		pins_t             pin2;
		access_st_t        st;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        base;
		logic [1:0]        beat;
		logic              data_oe;
		logic              asleep;
		logic              wr_ready;
	} port_state_t;
endpackage : sram_port_pkg

/* File: logic/sram_write_fifo.sv */
module sram_write_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input  wire logic             clk,       // Clock
	input  wire logic             rst_n,     // Synchronised reset, low
	input  wire logic [WIDTH-1:0] in_data,   // Word to store
	input  wire logic             in_valid,  // Word offered
	output wire logic             in_ready,  // Room for a word
	output wire logic [WIDTH-1:0] out_data,  // Oldest word
	output wire logic             out_valid, // Oldest word present
	input  wire logic             out_ready  // Oldest word taken
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW:0] wr;
		logic [PW:0] rd;
	} fifo_state_t;

	fifo_state_t      s;
	fifo_state_t      s_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("FIFO depth must be a power of two, width positive");
		end
	endgenerate

	// Extra pointer bit tells full from empty
	assign full      = (s.wr[PW] != s.rd[PW]) && (s.wr[PW-1:0] == s.rd[PW-1:0]);
	assign empty     = (s.wr == s.rd);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[s.rd[PW-1:0]];
	assign push      = in_valid & ~full;
	assign pop       = out_ready & ~empty;

	always_comb begin
		s_next = s;
		if (push) begin
			s_next.wr = s.wr + 1'b1;
		end
		if (pop) begin
			s_next.rd = s.rd + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= s_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[s.wr[PW-1:0]] <= in_data;
		end
	end
endmodule : sram_write_fifo

/* File: tb/bus_master_model.sv */
module bus_master_model
	import sram_port_pkg::*;
(
	input  wire logic              mclk,     // Clock
	input  wire logic [DATA_W-1:0] data_out, // Device drive value
	input  wire logic              data_oe,  // Device drives pins
	output var  pins_t             pins_o,   // Strobes, selects, address
	output wire logic [DATA_W-1:0] data_in   // Resolved data pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] last_reg;
	wire logic         wr_drive = !pins_o.gw_n || !pins_o.bwe_n;
	// Undriven pins show inverted history so a stale value never matches
	assign data_in = wr_drive ? pins_o.data : (data_oe ? data_out : ~last_reg);
	always @(posedge mclk) last_reg <= data_in;
	// Strap only moves under reset; reads keep byte write enable high, one processor-strobe read drives global write low
	task put(input pins_t p, input bit now);
		if (!now)
			@(posedge mclk);
		pins_o <= p;
	endtask : put
endmodule : bus_master_model

/* File: tb/tb_pipelined_burst_sram_port.sv */
module tb_pipelined_burst_sram_port
	import sram_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int t; logic [DATA_W-1:0] d;} exp_t;
	logic                   mclk = 1'b0;
	logic                   resetn = 1'b0;
	logic                   strap_v = 1'b0;
	logic [DATA_W-1:0]      lastd;
	pins_t                  pv;
	wire logic [DATA_W-1:0] dq_in, dq_out;
	wire logic              oe, wready, asleep;
	logic [DATA_W-1:0]      mem [int];
	logic                   oe_log [int];
	exp_t                   eq [$];
	int                     cyc = 0, err_total = 0, check_count = 0, seed = 58;

	always #20 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	bus_master_model mdl (.mclk(mclk), .data_out(dq_out), .data_oe(oe), .pins_o(pv), .data_in(dq_in));
	sram_burst_port uut (
		.mclk(mclk), .resetn(resetn), .address(pv.addr),
		.select_low_first(pv.sel_first_n), .select_high_second(pv.sel_second), .select_low_third(pv.sel_third_n),
		.processor_addr_strobe_n(pv.proc_n), .controller_addr_strobe_n(pv.ctrl_n), .burst_advance_n(pv.adv_n),
		.global_write_n(pv.gw_n), .byte_write_enable_n(pv.bwe_n), .byte_lane_select_n(pv.bw_n),
		.drive_enable_n(pv.oe_n), .sleep_request(pv.sleep), .burst_order_strap(pv.strap),
		.data_in(dq_in), .data_out(dq_out), .data_oe(oe), .write_ready(wready), .sleep_active(asleep)
	);

	task chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task end_sim();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	always @(posedge mclk) if (cyc == 5000) begin
		err_total++;
		end_sim();
	end

	// Pin-to-output latency is three edges
	always @(negedge mclk) begin
		oe_log[cyc] = oe;
		if (eq.size() != 0 && eq[0].t == cyc) begin
			chk(dq_out, eq[0].d);
			void'(eq.pop_front());
		end
	end

	function automatic pins_t nop();
		pins_t p = '0;
		p.sel_first_n = 1'b1;
		p.sel_second = 1'b1;
		p.proc_n = 1'b1;
		p.ctrl_n = 1'b1;
		p.adv_n = 1'b1;
		p.gw_n = 1'b1;
		p.bwe_n = 1'b1;
		p.bw_n = 4'hF;
		p.strap = strap_v;
		return p;
	endfunction : nop

	function automatic logic [1:0] nxt(logic [1:0] s, logic [1:0] b);
		return strap_v ? s ^ b : s + b;
	endfunction : nxt

	task ex(input logic [DATA_W-1:0] d);
		eq.push_back('{cyc + 4, d});
		lastd = d;
	endtask : ex

	task idle(input int n);
		pins_t p;
		p = nop();
		p.ctrl_n = 1'b0;
		repeat (n) mdl.put(p, 0);
	endtask : idle

	task rd(input logic [ADDR_W-1:0] a, input int md, input logic oen);
		pins_t p;
		p = nop();
		p.sel_first_n = 1'b0;
		p.addr = a;
		p.oe_n = oen;
		p.proc_n = (md == 1);
		p.ctrl_n = (md == 0);
		p.gw_n = (md != 2);
		mdl.put(p, 0);
		ex(mem[a]);
	endtask : rd

	task burst(input logic [ADDR_W-1:0] a);
		pins_t p;
		rd(a, 0, 1'b0);
		p = nop();
		p.sel_first_n = 1'b0;
		p.adv_n = 1'b0;
		for (int b = 1; b < 4; b++) begin
			mdl.put(p, 0);
			ex(mem[{a[ADDR_W-1:2], nxt(a[1:0], 2'(b))}]);
		end
	endtask : burst

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic gwn, input logic [3:0] bwn);
		pins_t             p;
		logic [DATA_W-1:0] o;
		p = nop();
		p.sel_first_n = 1'b0;
		p.ctrl_n = 1'b0;
		p.addr = a;
		p.data = d;
		p.gw_n = gwn;
		p.bwe_n = 1'b0;
		p.bw_n = bwn;
		p.oe_n = 1'b1;
		mdl.put(p, 0);
		o = mem[a];
		for (int l = 0; l < LANES; l++)
			if (!gwn || !bwn[l])
				o[l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
		mem[a] = o;
	endtask : wr

	task rst(input logic s);
		@(posedge mclk);
		resetn <= 1'b0;
		strap_v = s;
		mdl.put(nop(), 1);
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) mdl.put(nop(), 0);
		#1 chk({29'h0, oe, asleep, wready}, 32'h1);
	endtask : rst

	initial begin
		pins_t             p;
		int                s;
		logic [ADDR_W-1:0] b;
		mdl.put(nop(), 1);
		for (int m = 0; m < 2; m++) begin
			rst(m[0]);
			b = ADDR_W'($random(seed)) & 17'h1FFF8;
			// First pass full words so lane merges start from known data
			for (int i = 0; i < 16; i++)
				wr(b + ADDR_W'(i % 8), $random(seed), (i < 8) ? 1'b0 : 1'($random(seed)), 4'($random(seed)));
			idle(6);
			for (int j = 0; j < 2; j++)
				burst(b + ADDR_W'(4 * j) + ADDR_W'(2'($random(seed))));
			idle(4);
			for (int k = 0; k < 3; k++) begin
				rd(b, (k == 0) ? 2 : 0, k == 1);
				s = eq[$].t - 4;
				rd(b + 17'h1, 1, k == 1);
				if (k == 2)
					wr(b + 17'h2, $random(seed), 1'b0, 4'hF);
				else
					idle(1);
				idle(5);
				chk(oe_log[s + 4], 1'b0);
				chk(oe_log[s + 5], k != 1);
				chk(oe_log[s + 6], k != 2);
				chk(oe_log[s + 7], k == 2);
			end
			// Refused, deselecting or laneless byte-write starts leave the output register alone
			for (int v = 0; v < 4; v++) begin
				p = nop();
				p.sel_first_n = (v == 0);
				p.proc_n = (v != 0);
				p.ctrl_n = (v == 0);
				p.sel_second = (v != 1);
				p.sel_third_n = (v == 2);
				p.bwe_n = (v != 3);
				p.addr = b + 17'h3;
				mdl.put(p, 0);
				ex(lastd);
				idle(5);
			end
			p = nop();
			p.sleep = 1'b1;
			repeat (6) mdl.put(p, 0);
			#1 chk(asleep, 1'b1);
			repeat (5) mdl.put(nop(), 0);
			#1 chk(asleep, 1'b0);
			rd(b, 0, 1'b0);
			idle(5);
		end
		end_sim();
	end
endmodule : tb_pipelined_burst_sram_port
